//--- core/csrwb_regs.vh
`ifndef CSRWB_REGS_VH
`define CSRWB_REGS_VH

// Clock rates of the subsystem
`define CSRWB_CPU_HZ 500000000
`define CSRWB_MEMCTL_HZ 312500000
`define CSRWB_SUBSYS_HZ 250000000
`define CSRWB_CLK_HZ 200000000

// Watchdog timing
`define CSRWB_WDT_TIMEOUT_S 2
// Two seconds at the 200 MHz local clock, sized to the counter width
`define CSRWB_WDT_CYCLES 29'h17d78400
`define CSRWB_WDT_CNT_W 29

// Unlock keys, written alternately
`define CSRWB_WDT_KEY_A 8'hbe
`define CSRWB_WDT_KEY_B 8'hef

// Soft reset request length
`define CSRWB_RST_HOLD 4'h8

// Reset values
`define CSRWB_SCRATCH_RST 32'h00000000
`define CSRWB_PIN_ALT_RST 32'h00000000

// Shared bus regions, upper address nibble
`define CSRWB_NIB_LOW 4'h0
`define CSRWB_NIB_LOW_HI 4'h1
`define CSRWB_NIB_MEM0 4'h2
`define CSRWB_NIB_MEM1 4'h3
`define CSRWB_NIB_FLASH 4'h4
`define CSRWB_NIB_REGS 4'h7
`define CSRWB_NIB_RSV 4'h8
`define CSRWB_NIB_BIG_END 4'hb

// Target encodings
`define CSRWB_TGT_NONE 2'h0
`define CSRWB_TGT_FLASH 2'h1
`define CSRWB_TGT_MEM 2'h2
`define CSRWB_TGT_REGS 2'h3

// Transfer sizes and masters
`define CSRWB_SZ_BYTE 2'h0
`define CSRWB_SZ_HALF 2'h1
`define CSRWB_SZ_WORD 2'h2
`define CSRWB_MST_BAD 2'h3

`endif

//--- core/csrwb_top.v
// Summary of operation
// (RQ1) Core 500 MHz, memory controller 312.50 MHz, rest of subsystem 250 MHz.
// (RQ2) Subsystem trigger without CPU-only resets processor core and whole subsystem.
// (RQ3) With CPU-only set, soft reset hits core only; DMA, PCIe, memory run.
// (RQ4) Software disables frame DMA before any soft reset that reaches subsystem.
// (RQ5) Subsystem reset covers shared bus blocks, not switch register bus blocks.
// (RQ6) Chip trigger soft resets the whole device.
// (RQ7) Protect bit set keeps chip soft reset away from core and subsystem.
// (RQ8) Switch-core trigger does chip soft reset but spares SERDES and PLL.
// (RQ9) Scratch and pin alternate-function registers clear only on external reset.
// (RQ10) Watchdog times out after two seconds, starts disabled, own control only.
// (RQ11) Software restarts an enabled watchdog within the timeout period.
// (RQ12) Watchdog expiry acts as subsystem trigger, CPU-only still limits it.
// (RQ13) Out-of-sequence unlock key write fires an immediate expiry reset.
// (RQ14) Last reset cause shows watchdog or other; changes only at core reset.
// (RQ15) Enable or restart needs unlock key in same write as run bit.
// (RQ16) Shared bus: 32-bit address and data; only core, PCIe, access block master.
// (RQ17) Byte addressing, 8/16/32-bit transfers, bursts of 32-bit words.
// (RQ18) Boot mode after power-up or subsystem reset; normal mode mirrors memory.
// (RQ19) Boot map select written then read back; read applies new mapping.
// (RQ20) 512 MB mapped by default; large-memory enable extends map to 1 GB.
// (RQ21) Low mirror 0x0, memory 0x20000000, flash 0x40000000, registers 0x70000000.
// (RQ22) CPU-only soft reset leaves the current bus mapping unchanged.
// (RQ23) Each accepted restart reloads the full two-second countdown.
`timescale 1ns/1ps
`default_nettype none
`include "csrwb_regs.vh"

module csrwb_top #(
    parameter [`CSRWB_WDT_CNT_W-1:0] WDT_CYCLES = `CSRWB_WDT_CYCLES
) (
    // Clock and external reset
    input wire I_CLK,
    input wire I_RST_N,
    // Soft reset controls
    input wire I_SUBSYS_RST_TRIG,
    input wire I_CPU_ONLY,
    input wire I_PROTECT,
    input wire I_CHIP_RST_TRIG,
    input wire I_SWITCH_CORE_SOFT_RESET_TRIGGER,
    // Watchdog control
    input wire I_WATCHDOG_WR,
    input wire [7:0] I_WATCHDOG_UNLOCK_KEY,
    input wire I_WATCHDOG_RUN,
    // Persistent registers
    input wire I_SCRATCH_WR,
    input wire [31:0] I_SCRATCH_WDATA,
    input wire I_PIN_ALT_WR,
    input wire [31:0] I_PIN_ALT_WDATA,
    // Bus map control
    input wire I_BOOT_MAP_SELECT_WR,
    input wire I_BOOT_MAP_SELECT_WDATA,
    input wire I_BOOT_MAP_SELECT_RD,
    input wire I_LARGE_MEMORY_ENABLE,
    // Shared bus request
    input wire I_BUS_VALID,
    input wire [31:0] I_BUS_ADDR,
    input wire [1:0] I_BUS_SIZE,
    input wire [1:0] I_BUS_MASTER,
    input wire I_BUS_BURST,
    // Reset requests
    output wire O_CPU_RST_REQ,
    output wire O_SUBSYS_RST_REQ,
    output wire O_CHIP_RST_REQ,
    output wire O_SERDES_PLL_RST_REQ,
    // Watchdog status
    output wire O_WATCHDOG_RUN,
    output wire O_LAST_RESET_CAUSE,
    // Persistent register contents
    output wire [31:0] O_SCRATCH,
    output wire [31:0] O_PIN_ALT,
    // Bus map status
    output wire O_BOOT_MAP_SELECT_RDATA,
    output wire O_BOOT_ACTIVE,
    // Shared bus decode
    output wire O_DEC_VALID,
    output wire [1:0] O_DEC_TARGET,
    output wire [31:0] O_DEC_OFFSET,
    output wire O_DEC_ERR
);

////////////////////////////////////////////////////////////////////////////////

reg cpu_rst_reg;
reg sub_rst_reg;
reg chip_rst_reg;
reg serdes_rst_reg;
reg [3:0] hold_cnt_reg;
reg wdt_run_reg;
reg [`CSRWB_WDT_CNT_W-1:0] wdt_cnt_reg;
reg wdt_key_b_reg;
reg cause_reg;
reg [31:0] scratch_reg;
reg [31:0] pin_alt_reg;
reg boot_act_reg;
reg boot_pend_reg;
reg boot_rdata_reg;
reg dec_valid_reg;
reg [1:0] dec_tgt_reg;
reg [31:0] dec_off_reg;
reg dec_err_reg;

wire [7:0] key_expected;
wire key_ok;
wire wdt_expired;
wire wdt_fire;
wire chip_any;
wire trig_sub;
wire cpu_set;
wire sub_set;
wire chip_set;
wire serdes_set;
wire any_set;

////////////////////////////////////////////////////////////////////////////////
// Reset scopes

assign chip_any = I_CHIP_RST_TRIG | I_SWITCH_CORE_SOFT_RESET_TRIGGER;
assign trig_sub = I_SUBSYS_RST_TRIG | wdt_fire; // RQ12
assign cpu_set = trig_sub | (chip_any & ~I_PROTECT); // RQ2 RQ7
assign sub_set = (trig_sub & ~I_CPU_ONLY) | (chip_any & ~I_PROTECT); // RQ3 RQ7
assign chip_set = chip_any; // RQ6
assign serdes_set = I_CHIP_RST_TRIG; // RQ8
assign any_set = cpu_set | sub_set | chip_set;

// Requests hold a fixed length; a new trigger restarts the hold and widens the scope
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        hold_cnt_reg <= 4'h0;
        cpu_rst_reg <= 1'b0;
        sub_rst_reg <= 1'b0;
        chip_rst_reg <= 1'b0;
        serdes_rst_reg <= 1'b0;
    end else if (any_set) begin
        hold_cnt_reg <= `CSRWB_RST_HOLD - 4'h1;
        cpu_rst_reg <= cpu_rst_reg | cpu_set;
        sub_rst_reg <= sub_rst_reg | sub_set;
        chip_rst_reg <= chip_rst_reg | chip_set;
        serdes_rst_reg <= serdes_rst_reg | serdes_set;
    end else if (hold_cnt_reg != 4'h0) begin
        hold_cnt_reg <= hold_cnt_reg - 4'h1;
    end else begin
        cpu_rst_reg <= 1'b0;
        sub_rst_reg <= 1'b0;
        chip_rst_reg <= 1'b0;
        serdes_rst_reg <= 1'b0;
    end
end

// Subsystem request drives shared bus blocks only; register bus blocks follow chip
assign O_CPU_RST_REQ = cpu_rst_reg;
assign O_SUBSYS_RST_REQ = sub_rst_reg; // RQ5
assign O_CHIP_RST_REQ = chip_rst_reg;
assign O_SERDES_PLL_RST_REQ = serdes_rst_reg;

////////////////////////////////////////////////////////////////////////////////
// Watchdog

assign key_expected = wdt_key_b_reg ? `CSRWB_WDT_KEY_B : `CSRWB_WDT_KEY_A;
assign key_ok = (I_WATCHDOG_UNLOCK_KEY == key_expected);
assign wdt_expired = wdt_run_reg & (wdt_cnt_reg == {`CSRWB_WDT_CNT_W{1'b0}}); // RQ10
assign wdt_fire = wdt_expired | (I_WATCHDOG_WR & ~key_ok); // RQ13

// Counting at the local clock; the period is fixed in time, not in subsystem cycles
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        wdt_run_reg <= 1'b0; // RQ10
        wdt_cnt_reg <= {`CSRWB_WDT_CNT_W{1'b0}};
        wdt_key_b_reg <= 1'b0;
    end else if (cpu_set) begin
        wdt_run_reg <= 1'b0;
        wdt_cnt_reg <= {`CSRWB_WDT_CNT_W{1'b0}};
        wdt_key_b_reg <= 1'b0;
    end else if (I_WATCHDOG_WR && key_ok) begin
        wdt_key_b_reg <= ~wdt_key_b_reg;
        if (I_WATCHDOG_RUN) begin
            wdt_run_reg <= 1'b1; // RQ15
            wdt_cnt_reg <= WDT_CYCLES - 1'b1; // RQ23 RQ1
        end else begin
            wdt_run_reg <= 1'b0;
        end
    end else if (wdt_run_reg) begin
        wdt_cnt_reg <= wdt_cnt_reg - 1'b1;
    end
end

// Cause is latched only as the core reset starts
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        cause_reg <= 1'b0;
    end else if (cpu_set) begin
        cause_reg <= wdt_fire; // RQ14
    end
end

assign O_WATCHDOG_RUN = wdt_run_reg;
assign O_LAST_RESET_CAUSE = cause_reg;

////////////////////////////////////////////////////////////////////////////////
// Persistent registers, deliberately blind to soft resets

always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        scratch_reg <= `CSRWB_SCRATCH_RST; // RQ9
        pin_alt_reg <= `CSRWB_PIN_ALT_RST; // RQ9
    end else begin
        if (I_SCRATCH_WR) begin
            scratch_reg <= I_SCRATCH_WDATA;
        end
        if (I_PIN_ALT_WR) begin
            pin_alt_reg <= I_PIN_ALT_WDATA;
        end
    end
end

assign O_SCRATCH = scratch_reg;
assign O_PIN_ALT = pin_alt_reg;

////////////////////////////////////////////////////////////////////////////////
// Boot and normal mapping

// A write only stages the mode so code keeps fetching until the read back
always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        boot_act_reg <= 1'b1; // RQ18
        boot_pend_reg <= 1'b1;
        boot_rdata_reg <= 1'b1;
    end else if (sub_set) begin
        boot_act_reg <= 1'b1; // RQ18 RQ22
        boot_pend_reg <= 1'b1;
        boot_rdata_reg <= 1'b1;
    end else begin
        if (I_BOOT_MAP_SELECT_WR) begin
            boot_pend_reg <= I_BOOT_MAP_SELECT_WDATA;
        end
        if (I_BOOT_MAP_SELECT_RD) begin
            boot_act_reg <= boot_pend_reg; // RQ19
            boot_rdata_reg <= boot_pend_reg;
        end
    end
end

assign O_BOOT_MAP_SELECT_RDATA = boot_rdata_reg;
assign O_BOOT_ACTIVE = boot_act_reg;

////////////////////////////////////////////////////////////////////////////////
// Shared bus address decode

reg [1:0] tgt_next;
reg [31:0] off_next;
reg err_next;
wire [3:0] nib;
wire [31:0] mem_off;

assign nib = I_BUS_ADDR[31:28];
assign mem_off = I_LARGE_MEMORY_ENABLE ? {2'h0, I_BUS_ADDR[29:0]} :
                 {3'h0, I_BUS_ADDR[28:0]}; // RQ20

always @* begin
    tgt_next = `CSRWB_TGT_NONE;
    off_next = 32'h00000000;
    err_next = 1'b0;
    if (nib == `CSRWB_NIB_LOW) begin
        if (boot_act_reg) begin
            tgt_next = `CSRWB_TGT_FLASH; // RQ18 RQ21
            off_next = {4'h0, I_BUS_ADDR[27:0]};
        end else begin
            tgt_next = `CSRWB_TGT_MEM; // RQ18 RQ21
            off_next = mem_off;
        end
    end else if (nib == `CSRWB_NIB_LOW_HI) begin
        if (!boot_act_reg) begin
            tgt_next = `CSRWB_TGT_MEM;
            off_next = mem_off;
        end
    end else if (nib == `CSRWB_NIB_MEM0 || nib == `CSRWB_NIB_MEM1) begin
        if (!I_LARGE_MEMORY_ENABLE || !boot_act_reg) begin
            tgt_next = `CSRWB_TGT_MEM; // RQ20 RQ21
            off_next = mem_off;
        end
    end else if (nib == `CSRWB_NIB_FLASH) begin
        tgt_next = `CSRWB_TGT_FLASH; // RQ21
        off_next = {4'h0, I_BUS_ADDR[27:0]};
    end else if (nib == `CSRWB_NIB_REGS) begin
        tgt_next = `CSRWB_TGT_REGS; // RQ21
        off_next = {4'h0, I_BUS_ADDR[27:0]};
    end else if (nib >= `CSRWB_NIB_RSV && nib <= `CSRWB_NIB_BIG_END) begin
        if (I_LARGE_MEMORY_ENABLE) begin
            tgt_next = `CSRWB_TGT_MEM; // RQ20
            off_next = {2'h0, I_BUS_ADDR[29:0]};
        end
    end
    // Only the three masters, legal sizes, aligned, word-only bursts
    if (I_BUS_MASTER == `CSRWB_MST_BAD) begin
        err_next = 1'b1; // RQ16
    end else if (I_BUS_SIZE == 2'h3) begin
        err_next = 1'b1; // RQ17
    end else if (I_BUS_SIZE == `CSRWB_SZ_HALF && I_BUS_ADDR[0]) begin
        err_next = 1'b1; // RQ17
    end else if (I_BUS_SIZE == `CSRWB_SZ_WORD && I_BUS_ADDR[1:0] != 2'h0) begin
        err_next = 1'b1; // RQ17
    end else if (I_BUS_BURST && I_BUS_SIZE != `CSRWB_SZ_WORD) begin
        err_next = 1'b1; // RQ17
    end else if (tgt_next == `CSRWB_TGT_NONE) begin
        err_next = 1'b1;
    end
    if (err_next) begin
        tgt_next = `CSRWB_TGT_NONE;
        off_next = 32'h00000000;
    end
end

always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
        dec_valid_reg <= 1'b0;
        dec_tgt_reg <= `CSRWB_TGT_NONE;
        dec_off_reg <= 32'h00000000;
        dec_err_reg <= 1'b0;
    end else begin
        dec_valid_reg <= I_BUS_VALID;
        if (I_BUS_VALID) begin
            dec_tgt_reg <= tgt_next;
            dec_off_reg <= off_next;
            dec_err_reg <= err_next;
        end
    end
end

assign O_DEC_VALID = dec_valid_reg;
assign O_DEC_TARGET = dec_tgt_reg;
assign O_DEC_OFFSET = dec_off_reg;
assign O_DEC_ERR = dec_err_reg;

endmodule // csrwb_top

`default_nettype wire

//--- core/placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- bench/csrwb_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csrwb_properties (
    // Clock, reset, soft reset controls and scratch write
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_SUBSYS_RST_TRIG,
    input wire logic I_CPU_ONLY,
    input wire logic I_PROTECT,
    input wire logic I_CHIP_RST_TRIG,
    input wire logic I_SWITCH_CORE_SOFT_RESET_TRIGGER,
    input wire logic I_SCRATCH_WR,
    // Observed outputs
    input wire logic O_CPU_RST_REQ,
    input wire logic O_SUBSYS_RST_REQ,
    input wire logic O_CHIP_RST_REQ,
    input wire logic O_SERDES_PLL_RST_REQ,
    input wire logic O_LAST_RESET_CAUSE,
    input wire logic [31:0] O_SCRATCH
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // Requests stand eight cycles so slower domains surely see them
    sequence cpu_held;
        O_CPU_RST_REQ [*8];
    endsequence
    ////////////////////////////////////////
    sub_full_a: assert property (I_SUBSYS_RST_TRIG && !I_CPU_ONLY |=>
        O_CPU_RST_REQ && O_SUBSYS_RST_REQ) else $error("subsystem scope wrong");
    cpu_only_a: assert property (I_SUBSYS_RST_TRIG && I_CPU_ONLY && !O_SUBSYS_RST_REQ
        && !I_CHIP_RST_TRIG && !I_SWITCH_CORE_SOFT_RESET_TRIGGER |=> !O_SUBSYS_RST_REQ)
        else $error("cpu-only reset reached subsystem");
    chip_all_a: assert property (I_CHIP_RST_TRIG |=>
        O_CHIP_RST_REQ && O_SERDES_PLL_RST_REQ) else $error("chip reset scope wrong");
    protect_a: assert property ((I_CHIP_RST_TRIG || I_SWITCH_CORE_SOFT_RESET_TRIGGER)
        && !I_PROTECT |=> O_CPU_RST_REQ && O_SUBSYS_RST_REQ) else $error("unprotected core");
    swc_spare_a: assert property (I_SWITCH_CORE_SOFT_RESET_TRIGGER && !I_CHIP_RST_TRIG
        && !O_SERDES_PLL_RST_REQ |=> O_CHIP_RST_REQ && !O_SERDES_PLL_RST_REQ)
        else $error("switch-core reset scope wrong");
    cpu_hold_a: assert property ($rose(O_CPU_RST_REQ) |-> cpu_held)
        else $error("core request too short");
    scratch_keep_a: assert property (!I_SCRATCH_WR |=> $stable(O_SCRATCH))
        else $error("scratch changed without write");
    cause_core_a: assert property ($changed(O_LAST_RESET_CAUSE) |-> O_CPU_RST_REQ)
        else $error("cause changed outside core reset");
endmodule // csrwb_properties

bind csrwb_top csrwb_properties u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_SUBSYS_RST_TRIG(I_SUBSYS_RST_TRIG), .I_CPU_ONLY(I_CPU_ONLY), .I_PROTECT(I_PROTECT),
    .I_CHIP_RST_TRIG(I_CHIP_RST_TRIG), .I_SCRATCH_WR(I_SCRATCH_WR),
    .I_SWITCH_CORE_SOFT_RESET_TRIGGER(I_SWITCH_CORE_SOFT_RESET_TRIGGER),
    .O_CPU_RST_REQ(O_CPU_RST_REQ), .O_SUBSYS_RST_REQ(O_SUBSYS_RST_REQ),
    .O_CHIP_RST_REQ(O_CHIP_RST_REQ), .O_SERDES_PLL_RST_REQ(O_SERDES_PLL_RST_REQ),
    .O_LAST_RESET_CAUSE(O_LAST_RESET_CAUSE), .O_SCRATCH(O_SCRATCH));
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csrwb_regs.vh"
module tb;
    // Short timeout keeps expiry tests cheap
    localparam logic [`CSRWB_WDT_CNT_W-1:0] WD = 29'h32;
    int err_count = 0, samples_checked = 0;
    logic clk = 0, rst_n = 0, strg = 0, cpuo = 0, prot = 0, ctrg = 0, swc = 0;
    logic wwr = 0, wrun = 0, swr = 0, pwr = 0, bwr = 0, bwd = 0, brd = 0, lg = 0;
    logic bv = 0, bb = 0;
    logic [7:0] wkey = 8'h0;
    logic [31:0] sdat = 32'h0, pdat = 32'h0, ba = 32'h0;
    logic [1:0] bs = 2'h0, bm = 2'h0;
    wire cpu, sub, chip, ser, run, cause, bsel, boot, dv, derr;
    wire [1:0] dt;
    wire [31:0] scr, pin, doff;
    csrwb_top #(.WDT_CYCLES(WD)) dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_SUBSYS_RST_TRIG(strg), .I_CPU_ONLY(cpuo),
        .I_PROTECT(prot), .I_CHIP_RST_TRIG(ctrg), .I_SWITCH_CORE_SOFT_RESET_TRIGGER(swc),
        .I_WATCHDOG_WR(wwr), .I_WATCHDOG_UNLOCK_KEY(wkey), .I_WATCHDOG_RUN(wrun),
        .I_SCRATCH_WR(swr), .I_SCRATCH_WDATA(sdat), .I_PIN_ALT_WR(pwr),
        .I_PIN_ALT_WDATA(pdat), .I_BOOT_MAP_SELECT_WR(bwr), .I_BOOT_MAP_SELECT_WDATA(bwd),
        .I_BOOT_MAP_SELECT_RD(brd), .I_LARGE_MEMORY_ENABLE(lg), .I_BUS_VALID(bv),
        .I_BUS_ADDR(ba), .I_BUS_SIZE(bs), .I_BUS_MASTER(bm), .I_BUS_BURST(bb),
        .O_CPU_RST_REQ(cpu), .O_SUBSYS_RST_REQ(sub), .O_CHIP_RST_REQ(chip),
        .O_SERDES_PLL_RST_REQ(ser), .O_WATCHDOG_RUN(run), .O_LAST_RESET_CAUSE(cause),
        .O_SCRATCH(scr), .O_PIN_ALT(pin), .O_BOOT_MAP_SELECT_RDATA(bsel),
        .O_BOOT_ACTIVE(boot), .O_DEC_VALID(dv), .O_DEC_TARGET(dt), .O_DEC_OFFSET(doff),
        .O_DEC_ERR(derr));
    always #2.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t ns: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic trig(input logic [2:0] t);
        @(posedge clk);
        {strg, ctrg, swc} <= t;
        @(posedge clk);
        {strg, ctrg, swc} <= 3'h0;
        #1;
    endtask
    task automatic wd(input logic [7:0] k, input logic r);
        @(posedge clk);
        {wwr, wkey, wrun} <= {1'b1, k, r};
        @(posedge clk);
        wwr <= 1'b0;
        #1;
    endtask
    // Map only moves on the read, never on the write alone
    task automatic bmode(input logic v, input logic p);
        @(posedge clk);
        {bwr, bwd} <= {1'b1, v};
        @(posedge clk);
        {bwr, brd} <= 2'b01;
        #1 chk({boot, bsel}, {p, p});
        @(posedge clk);
        brd <= 1'b0;
        #1 chk({boot, bsel}, {v, v});
    endtask
    function automatic logic [34:0] dexp(input logic [31:0] a, input logic [1:0] s, m,
                                         input logic b, bt, big);
        logic [3:0] n;
        logic [1:0] t;
        logic [31:0] o;
        n = a[31:28];
        {t, o} = 34'h0;
        if ((n == 4'h0 && bt) || n == 4'h4) {t, o} = {2'h1, 4'h0, a[27:0]};
        else if (n == 4'h7) {t, o} = {2'h3, 4'h0, a[27:0]};
        else if (big ? (n[3:2] == 2'b10 || (!bt && n < 4)) : (n[3:1] == 3'h1 || (!bt && n < 2)))
            {t, o} = {2'h2, big ? {2'h0, a[29:0]} : {3'h0, a[28:0]}};
        if (m == 3 || s == 3 || (s == 1 && a[0]) || (s == 2 && a[1:0] != 0) || (b && s != 2)
            || t == 0) return {1'b1, 34'h0};
        return {1'b0, t, o};
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        report_and_stop;
    end
    initial begin
        logic [34:0] e;
        logic [31:0] a;
        logic [1:0] s, m;
        logic b;
        a = $urandom(32'h567e916d);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk({cpu, sub, chip, ser, run, cause, boot, bsel}, 8'h03);
        chk({scr, pin}, 64'h0);
        @(posedge clk);
        {swr, pwr, sdat, pdat} <= {2'b11, $urandom, $urandom};
        @(posedge clk);
        {swr, pwr} <= 2'b00;
        #1 chk({scr, pin}, {sdat, pdat});
        bmode(1'b0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            {cpuo, prot} <= {!i[0], i[0]};
            // No frame DMA in this block, so every trigger goes out as if it were disabled
            trig(i < 2 ? 3'h4 : (i < 4 ? 3'h2 : 3'h1));
            e = i < 2 ? {1'b1, i[0], 2'b00} : {!i[0], !i[0], 1'b1, i < 4};
            chk({cpu, sub, chip, ser}, e);
            cyc(7);
            chk({cpu, sub, chip, ser}, e);
            cyc(1);
            chk({cpu, sub, chip, ser, boot}, {4'h0, i != 0});
        end
        chk({scr, pin}, {sdat, pdat});
        for (int j = 0; j < 4; j++) begin
            bmode(!j[0], j != 2);
            for (int k = 0; k <= 40; k++) begin
                @(posedge clk);
                a = $urandom;
                {s, m, b} = 5'($urandom);
                if (a[4]) {s, m, a[1:0]} = {2'h2, a[6:5] % 2'h3, 2'h0};
                {lg, bv, ba, bs, bm, bb} <= {j[1], k < 40, a, s, m, b};
                #1 if (k > 0) chk({dv, derr, dt, doff}, {1'b1, e});
                e = dexp(a, s, m, b, !j[0], j[1]);
            end
            cyc(1);
            chk(dv, 0);
        end
        wd(`CSRWB_WDT_KEY_A, 1'b1);
        chk(run, 1);
        cyc(30);
        wd(`CSRWB_WDT_KEY_B, 1'b1);
        cyc(WD - 1);
        chk(cpu, 0);
        cyc(1);
        chk({cpu, sub, cause}, 3'h7);
        cyc(12);
        chk({run, cpu}, 2'h0);
        wd(`CSRWB_WDT_KEY_A, 1'b1);
        wd(`CSRWB_WDT_KEY_B, 1'b0);
        chk(run, 0);
        cyc(WD + 5);
        chk(cpu, 0);
        @(posedge clk);
        cpuo <= 1'b1;
        wd(`CSRWB_WDT_KEY_B, 1'b1);
        cyc(1);
        chk({cpu, sub, cause}, 3'h5);
        cyc(12);
        trig(3'h4);
        chk(cause, 0);
        cyc(12);
        // Only an external reset may clear the persistent registers
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk({scr, pin}, 64'h0);
        chk({cpu, sub, chip, ser, run, cause, boot, bsel}, 8'h03);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
